/* hdl/nmp_pkg.sv */
// Purpose: shared constants for the normal-mode pulse modulator edge generator
// Assumes: single clock, 4 ns period, all counts in clock ticks
// Notes:   widths fixed; counter and event values are 16-bit unsigned
package nmp_pkg;
   localparam int unsigned CNT_W        = 16;            // period counter width
   localparam int unsigned CLK_PERIOD_PS = 4000;         // 250 MHz core clock
   localparam logic [15:0] CNT_ZERO     = 16'h0000;      // counter restart value
   localparam logic [15:0] CNT_ONE      = 16'h0001;      // counter step
   localparam int unsigned HALF_SHIFT   = 1;             // divide-by-two of duty
   localparam logic        LVL_LOW      = 1'b0;          // output idle level
   localparam logic        LVL_HIGH     = 1'b1;          // output active level
   // adaptive sample point choice
   typedef enum logic [0:0] {
      NMP_SAMP_END = 1'b0,   // end of on-time
      NMP_SAMP_MID = 1'b1    // middle of on-time
   } nmp_samp_t;
   // phase trigger source choice
   typedef enum logic [0:0] {
      NMP_PH_REG  = 1'b0,    // fixed phase trigger value
      NMP_PH_DUTY = 1'b1     // loop filter duty
   } nmp_ph_t;
endpackage : nmp_pkg

/* hdl/nmp_edges.sv */
// Purpose: edge, trigger and blanking generator of one pulse modulator, normal mode
// Assumes: configuration inputs steady or updated freely; capture at period start
// Notes:   all outputs registered; a target beyond the period limit never fires
//
// How it works
// - counter runs zero to period limit, wraps
// - each signal changes when counter equals target
// - first output rises at event one
// - first output falls at e1+duty+adjust one
// - end choice: trigger at e1+duty+offset
// - mid choice: trigger at e1+duty/2+offset
// - second rises at fall plus (e3-e2)
// - second output falls at event four
// - phase point from register or filter duty
// - fixed triggers, blanking straight from registers
// - second cycle adjust ignored in normal mode
// - phase shift pulse emitted for peer modulators
// - filter-sourced phase follows duty changes
`timescale 1ns/1ps
module nmp_edges (
   input  wire logic                     core_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     enable_i,          // run the counter
   input  wire logic [15:0]              period_limit_i,
   input  wire logic [15:0]              event1_i,
   input  wire logic [15:0]              event2_i,
   input  wire logic [15:0]              event3_i,
   input  wire logic [15:0]              event4_i,
   input  wire logic [15:0]              cycle_adj_a_i,
   input  wire logic [15:0]              cycle_adj_b_i,     // unused in normal mode
   input  wire logic [15:0]              samp_offset_i,
   input  wire nmp_pkg::nmp_samp_t       samp_sel_i,
   input  wire logic [15:0]              phase_reg_i,
   input  wire nmp_pkg::nmp_ph_t         phase_sel_i,
   input  wire logic [15:0]              filt_duty_i,
   input  wire logic [15:0]              filt_period_i,     // carried for other modes
   input  wire logic [15:0]              samp_trig1_i,
   input  wire logic [15:0]              samp_trig2_i,
   input  wire logic [15:0]              blank_a_begin_i,
   input  wire logic [15:0]              blank_a_end_i,
   input  wire logic [15:0]              blank_b_begin_i,
   input  wire logic [15:0]              blank_b_end_i,
   output logic                          first_output_o,
   output logic                          second_output_o,
   output logic                          adapt_trig_o,
   output logic                          samp_trig1_o,
   output logic                          samp_trig2_o,
   output logic                          blank_a_o,
   output logic                          blank_b_o,
   output logic                          phase_shift_o,
   output logic                          period_start_o
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [15:0] cnt_q, cnt_d;
   logic [15:0] prd_q, prd_d;
   logic [15:0] a_rise_q, a_rise_d, a_fall_q, a_fall_d;
   logic [15:0] b_rise_q, b_rise_d, b_fall_q, b_fall_d;
   logic [15:0] adapt_q, adapt_d, phase_q, phase_d;
   logic [15:0] st1_q, st1_d, st2_q, st2_d;
   logic [15:0] bab_q, bab_d, bae_q, bae_d, bbb_q, bbb_d, bbe_q, bbe_d;
   logic        fa_q, fa_d, sb_q, sb_d, at_q, at_d, t1_q, t1_d, t2_q, t2_d;
   logic        ba_q, ba_d, bb_q, bb_d, ph_q, ph_d, ps_q, ps_d;
   logic        wrap;
   logic [15:0] a_fall_c, half_duty, dead_c;

   ////////////////////////////////////////////////////////////////////////
   // computed targets; the second adjust input is never read here
   always_comb begin
      half_duty = filt_duty_i >> nmp_pkg::HALF_SHIFT;
      dead_c    = 16'(event3_i - event2_i);
      a_fall_c  = 16'(event1_i + filt_duty_i + cycle_adj_a_i);
   end

   ////////////////////////////////////////////////////////////////////////
   // counter and period-start capture of every target
   always_comb begin
      wrap     = (cnt_q >= prd_q);
      cnt_d    = cnt_q;
      prd_d    = prd_q;
      a_rise_d = a_rise_q;
      a_fall_d = a_fall_q;
      b_rise_d = b_rise_q;
      b_fall_d = b_fall_q;
      adapt_d  = adapt_q;
      phase_d  = phase_q;
      st1_d    = st1_q;
      st2_d    = st2_q;
      bab_d    = bab_q;
      bae_d    = bae_q;
      bbb_d    = bbb_q;
      bbe_d    = bbe_q;
      ps_d     = 1'b0;
      if (enable_i) begin
         if (wrap) begin
            cnt_d    = nmp_pkg::CNT_ZERO;
            ps_d     = 1'b1;
            // capture once per period so edges use one consistent set
            prd_d    = period_limit_i;
            a_rise_d = event1_i;
            a_fall_d = a_fall_c;
            b_rise_d = 16'(a_fall_c + dead_c);
            b_fall_d = event4_i;
            if (samp_sel_i == nmp_pkg::NMP_SAMP_MID)
               adapt_d = 16'(event1_i + half_duty + samp_offset_i);
            else
               adapt_d = 16'(event1_i + filt_duty_i + samp_offset_i);
            // duty source lets filter changes steer peer phase
            phase_d  = (phase_sel_i == nmp_pkg::NMP_PH_DUTY) ?
                       filt_duty_i : phase_reg_i;
            st1_d    = samp_trig1_i;
            st2_d    = samp_trig2_i;
            bab_d    = blank_a_begin_i;
            bae_d    = blank_a_end_i;
            bbb_d    = blank_b_begin_i;
            bbe_d    = blank_b_end_i;
         end else begin
            cnt_d = 16'(cnt_q + nmp_pkg::CNT_ONE);
         end
      end else begin
         cnt_d = nmp_pkg::CNT_ZERO;
      end
   end

   // a zero limit after reset makes the first enabled edge wrap and load every target
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q    <= nmp_pkg::CNT_ZERO;
         prd_q    <= nmp_pkg::CNT_ZERO;
         a_rise_q <= nmp_pkg::CNT_ZERO;
         a_fall_q <= nmp_pkg::CNT_ZERO;
         b_rise_q <= nmp_pkg::CNT_ZERO;
         b_fall_q <= nmp_pkg::CNT_ZERO;
         adapt_q  <= nmp_pkg::CNT_ZERO;
         phase_q  <= nmp_pkg::CNT_ZERO;
         st1_q    <= nmp_pkg::CNT_ZERO;
         st2_q    <= nmp_pkg::CNT_ZERO;
         bab_q    <= nmp_pkg::CNT_ZERO;
         bae_q    <= nmp_pkg::CNT_ZERO;
         bbb_q    <= nmp_pkg::CNT_ZERO;
         bbe_q    <= nmp_pkg::CNT_ZERO;
         ps_q     <= 1'b0;
      end else begin
         cnt_q    <= cnt_d;
         prd_q    <= prd_d;
         a_rise_q <= a_rise_d;
         a_fall_q <= a_fall_d;
         b_rise_q <= b_rise_d;
         b_fall_q <= b_fall_d;
         adapt_q  <= adapt_d;
         phase_q  <= phase_d;
         st1_q    <= st1_d;
         st2_q    <= st2_d;
         bab_q    <= bab_d;
         bae_q    <= bae_d;
         bbb_q    <= bbb_d;
         bbe_q    <= bbe_d;
         ps_q     <= ps_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // match-driven levels and pulses; a level holds until its own match
   always_comb begin
      fa_d = fa_q;
      sb_d = sb_q;
      ba_d = ba_q;
      bb_d = bb_q;
      if (!enable_i) begin
         fa_d = nmp_pkg::LVL_LOW;
         sb_d = nmp_pkg::LVL_LOW;
         ba_d = nmp_pkg::LVL_LOW;
         bb_d = nmp_pkg::LVL_LOW;
      end else begin
         // falling edge checked last so a zero-width pulse stays low
         if (cnt_q == a_rise_q) fa_d = nmp_pkg::LVL_HIGH;
         if (cnt_q == a_fall_q) fa_d = nmp_pkg::LVL_LOW;
         if (cnt_q == b_rise_q) sb_d = nmp_pkg::LVL_HIGH;
         if (cnt_q == b_fall_q) sb_d = nmp_pkg::LVL_LOW;
         if (cnt_q == bab_q) ba_d = nmp_pkg::LVL_HIGH;
         if (cnt_q == bae_q) ba_d = nmp_pkg::LVL_LOW;
         if (cnt_q == bbb_q) bb_d = nmp_pkg::LVL_HIGH;
         if (cnt_q == bbe_q) bb_d = nmp_pkg::LVL_LOW;
      end
      at_d = enable_i && (cnt_q == adapt_q);
      t1_d = enable_i && (cnt_q == st1_q);
      t2_d = enable_i && (cnt_q == st2_q);
      ph_d = enable_i && (cnt_q == phase_q);
   end

   // levels come up low so the gate drivers see both switches off after reset
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fa_q <= nmp_pkg::LVL_LOW;
         sb_q <= nmp_pkg::LVL_LOW;
         at_q <= 1'b0;
         t1_q <= 1'b0;
         t2_q <= 1'b0;
         ba_q <= nmp_pkg::LVL_LOW;
         bb_q <= nmp_pkg::LVL_LOW;
         ph_q <= 1'b0;
      end else begin
         fa_q <= fa_d;
         sb_q <= sb_d;
         at_q <= at_d;
         t1_q <= t1_d;
         t2_q <= t2_d;
         ba_q <= ba_d;
         bb_q <= bb_d;
         ph_q <= ph_d;
      end
   end

   assign first_output_o  = fa_q;
   assign second_output_o = sb_q;
   assign adapt_trig_o    = at_q;
   assign samp_trig1_o    = t1_q;
   assign samp_trig2_o    = t2_q;
   assign blank_a_o       = ba_q;
   assign blank_b_o       = bb_q;
   assign phase_shift_o   = ph_q;
   assign period_start_o  = ps_q;

   ////////////////////////////////////////////////////////////////////////
   // checks; the releasing edge of reset still clears the flops, so the sampled
   // reset keeps look-ahead checks from starting on that edge
   chk_cnt_bound: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i |-> cnt_q <= prd_q || cnt_q == 16'h0000 || $past(cnt_q) == prd_q)
      else $error("counter passed period limit");
   chk_cnt_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !rst_i && enable_i && cnt_q >= prd_q ##1 enable_i |->
      cnt_q == 16'h0000 && period_start_o)
      else $error("counter failed to wrap");
   chk_a_rise: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i && cnt_q == a_rise_q && cnt_q != a_fall_q |=> first_output_o)
      else $error("first output missed rise");
   chk_a_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i && cnt_q == a_fall_q |=> !first_output_o)
      else $error("first output missed fall");
   chk_b_rise: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i && cnt_q == b_rise_q && cnt_q != b_fall_q |=> second_output_o)
      else $error("second output missed rise");
   chk_b_fall: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i && cnt_q == b_fall_q |=> !second_output_o)
      else $error("second output missed fall");
   chk_hold_lvl: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i && $past(enable_i) && $past(cnt_q) != $past(a_rise_q)
      && $past(cnt_q) != $past(a_fall_q) |-> $stable(first_output_o))
      else $error("first output moved off edge");
   chk_b_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i && $past(enable_i) && $past(cnt_q) != $past(b_rise_q)
      && $past(cnt_q) != $past(b_fall_q) |-> $stable(second_output_o))
      else $error("second output moved off edge");
   chk_blank_a_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i && cnt_q == bae_q |=> !blank_a_o)
      else $error("blanking a missed end");
   chk_blank_b_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
      enable_i && cnt_q == bbe_q |=> !blank_b_o)
      else $error("blanking b missed end");
   chk_fix_trig: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !rst_i && enable_i && cnt_q == st1_q |=>
      samp_trig1_o ##1 !samp_trig1_o || cnt_q == 16'h0001)
      else $error("fixed sample trigger wrong");
   chk_trig2_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
      samp_trig2_o |-> $past(enable_i) && $past(cnt_q) == $past(st2_q))
      else $error("second sample trigger at wrong count");
   chk_adapt_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
      adapt_trig_o |-> $past(enable_i) && $past(cnt_q) == $past(adapt_q))
      else $error("adaptive trigger at wrong count");
   chk_phase_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
      phase_shift_o |-> $past(cnt_q) == $past(phase_q) && $past(enable_i))
      else $error("phase pulse at wrong count");
   // targets loaded at period start, restated from the edge equations
   chk_prd_capture: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> prd_q == $past(period_limit_i))
      else $error("period limit not captured");
   chk_rise_tgt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> a_rise_q == $past(event1_i))
      else $error("first output rise target wrong");
   chk_fall_tgt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> a_fall_q ==
      16'($past(event1_i) + $past(filt_duty_i) + $past(cycle_adj_a_i)))
      else $error("first output fall target wrong");
   chk_dead_gap: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> b_rise_q == 16'(a_fall_q + $past(event3_i) - $past(event2_i)))
      else $error("dead time target wrong");
   chk_b_fall_tgt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> b_fall_q == $past(event4_i))
      else $error("second output fall target wrong");
   chk_adapt_tgt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> adapt_q == 16'($past(event1_i) + $past(samp_offset_i)
      + (($past(samp_sel_i) == nmp_pkg::NMP_SAMP_MID) ?
      ($past(filt_duty_i) >> nmp_pkg::HALF_SHIFT) : $past(filt_duty_i))))
      else $error("adaptive trigger target wrong");
   chk_phase_tgt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> phase_q == (($past(phase_sel_i) == nmp_pkg::NMP_PH_DUTY) ?
      $past(filt_duty_i) : $past(phase_reg_i)))
      else $error("phase target wrong");
   chk_fix_tgt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> st1_q == $past(samp_trig1_i) && st2_q == $past(samp_trig2_i))
      else $error("fixed trigger target wrong");
   chk_blank_tgt: assert property (@(posedge core_clk_i) disable iff (rst_i)
      period_start_o |-> bab_q == $past(blank_a_begin_i) && bae_q == $past(blank_a_end_i)
      && bbb_q == $past(blank_b_begin_i) && bbe_q == $past(blank_b_end_i))
      else $error("blanking target wrong");
   chk_mid_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !rst_i && enable_i && cnt_q < prd_q |=> $stable(a_fall_q) && $stable(b_rise_q)
      && $stable(adapt_q) && $stable(phase_q) && $stable(prd_q))
      else $error("target moved inside a period");

endmodule : nmp_edges

/* bench/nmp_filt_model.sv */
// Purpose: loop filter stand-in that feeds duty and period values to the modulator
// Assumes: one new pair per switching period, just after period start
// Notes:   duty steps through a fixed pattern so that it moves every period
`timescale 1ns/1ps
module nmp_filt_model (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        period_start_i,
   output logic [15:0]      duty_o,
   output logic [15:0]      period_o
);
   // update right after period start on purpose: the modulator must ignore it until the next wrap
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         duty_o   <= 16'h0004;
         period_o <= 16'h0008;
      end else if (period_start_i) begin
         duty_o   <= (duty_o + 16'h0005) & 16'h000F;
         period_o <= {duty_o[14:0], 1'b0};
      end
   end
endmodule : nmp_filt_model

/* bench/test_nmp_edges.sv */
// Purpose: self-checking bench for the normal-mode edge generator
// Assumes: enable dropped now and then; configuration re-drawn at random moments
// Notes:   reference model compares every output on every cycle after its second wrap
`timescale 1ns/1ps
module test_nmp_edges;
   logic clk = 1'b0;
   logic rst, en, fo, so, at, t1, t2, ba, bb, ph, ps, mf, ms, ma, m1, m2, mba, mbb, mph, mps;
   logic [15:0] lim, e1, e2, e3, e4, ca, cb, ofs, preg, duty, per, st1, st2, bab, bae, bbb, bbe;
   logic [15:0] tr1, tf1, tr2, tf2, tad, tph, ts1, ts2, tab, tae, tbb, tbe, lfsr;
   nmp_pkg::nmp_samp_t ssel;
   nmp_pkg::nmp_ph_t   psel;
   int miscompares = 0;
   int n_checks = 0;
   int m_cnt, m_lim, nwr;
   nmp_edges dut (.core_clk_i(clk), .rst_i(rst), .enable_i(en), .period_limit_i(lim),
      .event1_i(e1), .event2_i(e2), .event3_i(e3), .event4_i(e4), .cycle_adj_a_i(ca),
      .cycle_adj_b_i(cb), .samp_offset_i(ofs), .samp_sel_i(ssel), .phase_reg_i(preg),
      .phase_sel_i(psel), .filt_duty_i(duty), .filt_period_i(per), .samp_trig1_i(st1),
      .samp_trig2_i(st2), .blank_a_begin_i(bab), .blank_a_end_i(bae), .blank_b_begin_i(bbb),
      .blank_b_end_i(bbe), .first_output_o(fo), .second_output_o(so), .adapt_trig_o(at),
      .samp_trig1_o(t1), .samp_trig2_o(t2), .blank_a_o(ba), .blank_b_o(bb),
      .phase_shift_o(ph), .period_start_o(ps));
   nmp_filt_model filt (.core_clk_i(clk), .rst_i(rst), .period_start_i(ps), .duty_o(duty),
      .period_o(per));
   ////////////////////////////////////////////////////////////////////////////////
   // 250 MHz clock
   always #2 clk = ~clk;
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction : rnd
   // small events keep every dynamic target below the shortest period limit
   task automatic cfg();
      logic [15:0] l;
      logic [15:0] a;
      l = 16'h0028 + (rnd() & 16'h003F);
      a = rnd() & 16'h0007;
      lim <= l;
      e1 <= rnd() & 16'h0007;
      e2 <= a;
      e3 <= a + (rnd() & 16'h0003);
      e4 <= rnd() % l;
      ca <= rnd() & 16'h0003;
      cb <= rnd();
      ofs <= rnd() & 16'h0007;
      ssel <= nmp_pkg::nmp_samp_t'(rnd() % 2);
      psel <= nmp_pkg::nmp_ph_t'(rnd() % 2);
      preg <= rnd() % l;
      st1 <= rnd() % l;
      st2 <= rnd() % l;
      bab <= rnd() % l;
      bae <= rnd() % l;
      bbb <= rnd() % l;
      bbe <= rnd() % l;
   endtask : cfg
   ////////////////////////////////////////////////////////////////////////////////
   // reference: compare against targets held since the last wrap, then wrap and capture
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         {m_cnt, m_lim, nwr} = '0;
         {tr1, tf1, tr2, tf2, tad, tph, ts1, ts2, tab, tae, tbb, tbe} = '0;
         {mf, ms, ma, m1, m2, mba, mbb, mph, mps} = '0;
      end else if (!en) begin
         // a stopped counter sits at zero with every output low; targets are kept
         m_cnt = 0;
         {mf, ms, ma, m1, m2, mba, mbb, mph, mps} = '0;
      end else begin
         mps = (m_cnt >= m_lim);
         ma = (m_cnt == tad);
         m1 = (m_cnt == ts1);
         m2 = (m_cnt == ts2);
         mph = (m_cnt == tph);
         mf = (m_cnt == tf1) ? 1'b0 : (m_cnt == tr1) ? 1'b1 : mf;
         ms = (m_cnt == tf2) ? 1'b0 : (m_cnt == tr2) ? 1'b1 : ms;
         mba = (m_cnt == tae) ? 1'b0 : (m_cnt == tab) ? 1'b1 : mba;
         mbb = (m_cnt == tbe) ? 1'b0 : (m_cnt == tbb) ? 1'b1 : mbb;
         m_cnt = m_cnt + 1;
         if (mps) begin
            nwr = nwr + 1;
            m_cnt = 0;
            m_lim = lim;
            tr1 = e1;
            tf1 = e1 + duty + ca;
            tr2 = tf1 + (e3 - e2);
            tf2 = e4;
            tad = e1 + ((ssel == nmp_pkg::NMP_SAMP_MID) ? (duty >> 1) : duty) + ofs;
            tph = (psel == nmp_pkg::NMP_PH_DUTY) ? duty : preg;
            {ts1, ts2, tab, tae, tbb, tbe} = {st1, st2, bab, bae, bbb, bbe};
         end
      end
   end
   task automatic chk(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // compare on the falling edge, where registered outputs are settled
   always @(negedge clk) begin
      if (nwr >= 2) begin
         chk(fo, mf);
         chk(so, ms);
         chk(at, ma);
         chk(t1, m1);
         chk(t2, m2);
         chk(ba, mba);
         chk(bb, mbb);
         chk(ph, mph);
         chk(ps, mps);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (miscompares == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   // watchdog: about seven times the expected run length
   initial begin
      #(24000 * 4);
      miscompares++;
      report_and_stop();
   end
   // reconfigure at random points, often mid-period, to exercise capture at wrap
   initial begin
      lfsr = 16'h0044;
      rst <= 1'b1;
      en <= 1'b1;
      cfg();
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (40) begin
         repeat (37 + rnd() % 97) @(posedge clk);
         cfg();
         // about one interval in eight runs with the counter stopped
         en <= (rnd() % 16'h0008) != 16'h0000;
      end
      report_and_stop();
   end
endmodule : test_nmp_edges
